// >>> rtl/fic_chan_if.sv
// one channel's link between the register bank and its input front end
// assumes both ends run on sys_clk
`timescale 1ns/10ps
interface fic_chan_if;
  fic_pkg::fic_fmt_t fmt;
  logic pin_dir;
  logic sh_src;
  logic time_sel;
  logic filt_upd;
  logic div_tick;
  logic dbit;
  logic dstb;
  logic edge_seen;
  logic [15:0] tval;
  logic tstb;
  logic [10:0] man_per;
  logic clk_out;
  logic clk_oe;
  modport ctl (output fmt, pin_dir, sh_src, time_sel, filt_upd, div_tick,
    input dbit, dstb, edge_seen, tval, tstb, man_per, clk_out, clk_oe);
  modport fe (input fmt, pin_dir, sh_src, time_sel, filt_upd, div_tick,
    output dbit, dstb, edge_seen, tval, tstb, man_per, clk_out, clk_oe);
endinterface

// >>> rtl/fic_front.sv
// input format decode, clock pin driver and time measure for one channel
// assumes pins are synchronous to sys_clk
`timescale 1ns/10ps
module fic_front #(
  parameter int unsigned MAN_MIN = 6
) (
  input wire logic sys_clk,
  input wire logic rst,
  fic_chan_if.fe ch,
  input wire logic mclk_in,
  input wire logic mdat,
  input wire logic sample_hold_a,
  input wire logic sample_hold_b
);
  typedef struct packed {
    logic clk_q;
    logic dat_q;
    logic sh_q;
    logic phase;
    logic clk_out;
    logic clk_oe;
    logic dbit;
    logic dstb;
    logic edge_seen;
    logic [10:0] man_cnt;
    logic [10:0] man_per;
    logic [15:0] tcnt;
    logic [15:0] tval;
    logic tstb;
  } fic_fe_st_t;
  fic_fe_st_t st, nx;
  logic cur_clk, rise, fall, dedge, sh_sel, sh_rise;

  // own divided clock is used when the pin is driven out
  assign cur_clk = ch.pin_dir ? st.clk_out : mclk_in;
  assign rise = cur_clk & ~st.clk_q;
  assign fall = ~cur_clk & st.clk_q;
  assign dedge = mdat ^ st.dat_q;
  assign sh_sel = ch.sh_src ? sample_hold_b : sample_hold_a;
  assign sh_rise = sh_sel & ~st.sh_q;

  always_comb begin
    nx = st;
    nx.clk_q = cur_clk;
    nx.dat_q = mdat;
    nx.sh_q = sh_sel;
    nx.clk_oe = ch.pin_dir;
    if (ch.pin_dir && ch.div_tick) begin
      nx.clk_out = ~st.clk_out;
    end
    nx.dstb = 1'b0;
    nx.tstb = 1'b0;
    nx.edge_seen = (ch.fmt == fic_pkg::FMT_MAN) ? dedge : rise;
    if (st.man_cnt != 11'h7ff) begin
      nx.man_cnt = st.man_cnt + 11'h001;
    end
    case (ch.fmt)
      fic_pkg::FMT_1X: begin
        if (rise) begin
          nx.dbit = mdat;
          nx.dstb = 1'b1;
        end
      end
      fic_pkg::FMT_HALF: begin
        if (rise || fall) begin
          nx.dbit = mdat;
          nx.dstb = 1'b1;
        end
      end
      fic_pkg::FMT_DBL: begin
        if (rise) begin
          nx.phase = ~st.phase;
          nx.dstb = st.phase;
          nx.dbit = st.phase ? mdat : st.dbit;
        end
      end
      fic_pkg::FMT_MAN: begin
        // short gaps are bit-boundary edges and carry no data
        if (dedge && st.man_cnt >= 11'(MAN_MIN)) begin
          nx.dbit = mdat;
          nx.dstb = 1'b1;
          nx.man_per = st.man_cnt;
          nx.man_cnt = 11'h000;
        end
      end
      default: begin
        nx.dstb = 1'b0;
      end
    endcase
    if (st.tcnt != 16'hffff) begin
      nx.tcnt = st.tcnt + 16'h0001;
    end
    if (!ch.time_sel && ch.filt_upd) begin
      nx.tcnt = 16'h0000;
    end
    if (sh_rise) begin
      nx.tval = st.tcnt;
      nx.tstb = 1'b1;
      if (ch.time_sel) begin
        nx.tcnt = 16'h0000;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign ch.dbit = st.dbit;
  assign ch.dstb = st.dstb;
  assign ch.edge_seen = st.edge_seen;
  assign ch.tval = st.tval;
  assign ch.tstb = st.tstb;
  assign ch.man_per = st.man_per;
  assign ch.clk_out = st.clk_out;
  assign ch.clk_oe = st.clk_oe;

  a_fmt_single: assert property (@(posedge sys_clk) disable iff (rst)
    (ch.fmt == fic_pkg::FMT_1X && rise) |=> st.dstb && st.dbit == $past(mdat))
    else $error("single-rate bit not taken");
  a_fmt_slow: assert property (@(posedge sys_clk) disable iff (rst)
    (ch.fmt == fic_pkg::FMT_DBL && rise && !st.phase) |=> !st.dstb)
    else $error("double-rate clock took a bit on first edge");
  a_time_gap: assert property (@(posedge sys_clk) disable iff (rst)
    (ch.time_sel && sh_rise) |=> st.tstb && st.tcnt == 16'h0000)
    else $error("edge-to-edge timer not restarted");
  a_pin_dir: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> st.clk_oe == $past(ch.pin_dir))
    else $error("clock pin enable does not follow direction");
endmodule

// >>> rtl/fic_pkg.sv
// constants and types shared by the flag and channel control block
// assumes one 10 MHz system clock and a 7-bit register address space
package fic_pkg;
  localparam int NCH = 4;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam logic [6:0] FLAG_ADDR = 7'h00;
  localparam logic [3:0][6:0] CTRL_ADDR = {7'h13, 7'h0d, 7'h07, 7'h01};
  localparam logic [3:0][6:0] DATA_ADDR = {7'h23, 7'h21, 7'h1f, 7'h1d};
  localparam int MF_LSB = 8;
  localparam int ACK_LSB = 12;
  localparam int IRQ_W = 12;
  localparam int CTRL_W = 5;
  localparam int STAT_W = 11;
  localparam int STAT_LSB = 5;
  localparam int PIN_DIR_BIT = 4;
  localparam int SH_SRC_BIT = 3;
  localparam int TIME_SEL_BIT = 2;
  localparam int FMT_LSB = 0;
  localparam logic [15:0] FLAG_RST = 16'h0000;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [10:0] STAT_RST = 11'h000;
  localparam int unsigned SYS_CLK_HZ = 10_000_000;
  // watchdog trips when the modulator clock runs below sys_clk / WD_RATIO
  localparam int unsigned WD_RATIO = 64;
  localparam int unsigned WD_LIMIT = WD_RATIO;
  localparam int WD_W = 7;
  typedef enum logic [1:0] {
    FMT_1X = 2'b00,
    FMT_HALF = 2'b01,
    FMT_MAN = 2'b10,
    FMT_DBL = 2'b11
  } fic_fmt_t;
endpackage

// >>> rtl/fic_top.sv
// flag register and four channel control registers with their front ends
// assumes host bus strobes are one cycle, synchronous to sys_clk
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps

// Functional notes
// - one flag word at offset zero, twelve event flags plus four new-data flags
// - high flag set while enabled comparator output is at or above high threshold
// - low flag set while enabled comparator output is at or below low threshold
// - reading flags clears only those whose source has gone away
// - bits 11..8 hold modulator failure flags, channel 4 highest
// - bits 15..12 hold new-data flags, channel 4 highest
// - a new-data flag clears on its data word read, not flag read
// - channel control words sit at offsets 0x01, 0x07, 0x0d, 0x13
// - bits 15..5 of control are read-only decoder calibration status
// - bit 4 makes clock pin an input or driven divider output
// - bit 3 picks sample-hold signal a or b
// - time mode 0 measures filter update to latest sample-hold rise
// - time mode 1 measures between two sample-hold rises
// - format 00 takes one bit per modulator clock
// - format 01 takes two bits per modulator clock
// - format 10 decodes a Manchester stream
// - format 11 takes one bit every two modulator clocks
// - watchdog flags a modulator clock slower than sys_clk over 64
// - interrupt pin active while any event flag is set, polarity selectable
// - new-data pin active while any new-data flag is set, polarity selectable
// - new-data flag never sets while its enable is low
module fic_top #(
  parameter int unsigned CLK_DIV = 4,
  parameter int unsigned MAN_MIN = 6,
  parameter int unsigned WD_LIMIT = fic_pkg::WD_LIMIT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [3:0][15:0] cmp_val,
  input wire logic [3:0][15:0] thr_high,
  input wire logic [3:0][15:0] thr_low,
  input wire logic [3:0] high_irq_en,
  input wire logic [3:0] low_irq_en,
  input wire logic [3:0] mod_fail_irq_en,
  input wire logic irq_master_en,
  input wire logic [3:0] new_data_flag_enable,
  input wire logic [3:0] filt_upd,
  input wire logic interrupt_polarity,
  input wire logic new_data_pin_polarity,
  input wire logic [3:0] modulator_clock_pin_in,
  output logic [3:0] modulator_clock_pin_out,
  output logic [3:0] modulator_clock_pin_oe,
  input wire logic [3:0] mod_data,
  input wire logic sample_hold_a,
  input wire logic sample_hold_b,
  output logic [3:0] mod_bit,
  output logic [3:0] mod_bit_stb,
  output logic [3:0][15:0] time_val,
  output logic [3:0] time_stb,
  output logic int_pin,
  output logic new_data_pin
);
  typedef struct packed {
    logic [15:0] flags;
    logic [3:0][4:0] ctrl;
    logic [3:0][10:0] mstat;
    logic [15:0] rdata;
    logic int_pin;
    logic ack_pin;
    logic [7:0] div_cnt;
    logic div_tick;
  } fic_top_st_t;

  fic_top_st_t st, nx;
  fic_chan_if ch_if[fic_pkg::NCH] ();

  logic [3:0] hi_src;
  logic [3:0] lo_src;
  logic [3:0] mf_src;
  logic [3:0] wd_fail;
  logic [3:0] ack_set;
  logic [3:0] data_rd;
  logic [3:0] ctrl_wr;
  logic [3:0] ctrl_rd;
  logic [3:0][10:0] man_per;
  logic [11:0] src12;
  logic flag_rd;
  logic [4:0] wlow;
  logic any_irq;
  logic any_ack;

  assign flag_rd = reg_rd && (reg_addr == fic_pkg::FLAG_ADDR);
  assign wlow = reg_wdata[4:0];
  assign any_irq = |st.flags[11:0];
  assign any_ack = |st.flags[15:12];

  genvar g;
  generate
    for (g = 0; g < fic_pkg::NCH; g++) begin : g_ch
      // comparator values and thresholds are two's complement
      assign hi_src[g] = irq_master_en && high_irq_en[g] &&
        ($signed(cmp_val[g]) >= $signed(thr_high[g]));
      assign lo_src[g] = irq_master_en && low_irq_en[g] &&
        ($signed(cmp_val[g]) <= $signed(thr_low[g]));
      assign mf_src[g] = irq_master_en && mod_fail_irq_en[g] && wd_fail[g];
      assign src12[2*g] = hi_src[g];
      assign src12[2*g+1] = lo_src[g];
      assign src12[fic_pkg::MF_LSB+g] = mf_src[g];
      assign ack_set[g] = filt_upd[g] && new_data_flag_enable[g];
      assign data_rd[g] = reg_rd && (reg_addr == fic_pkg::DATA_ADDR[g]);
      assign ctrl_wr[g] = reg_wr && (reg_addr == fic_pkg::CTRL_ADDR[g]);
      assign ctrl_rd[g] = reg_rd && (reg_addr == fic_pkg::CTRL_ADDR[g]);
      assign man_per[g] = ch_if[g].man_per;

      assign ch_if[g].fmt = fic_pkg::fic_fmt_t'(st.ctrl[g][1:0]);
      assign ch_if[g].pin_dir = st.ctrl[g][fic_pkg::PIN_DIR_BIT];
      assign ch_if[g].sh_src = st.ctrl[g][fic_pkg::SH_SRC_BIT];
      assign ch_if[g].time_sel = st.ctrl[g][fic_pkg::TIME_SEL_BIT];
      assign ch_if[g].filt_upd = filt_upd[g];
      assign ch_if[g].div_tick = st.div_tick;

      fic_front #(
        .MAN_MIN(MAN_MIN)
      ) u_front (
        .sys_clk(sys_clk),
        .rst(rst),
        .ch(ch_if[g]),
        .mclk_in(modulator_clock_pin_in[g]),
        .mdat(mod_data[g]),
        .sample_hold_a(sample_hold_a),
        .sample_hold_b(sample_hold_b)
      );

      fic_wdog #(
        .LIMIT(WD_LIMIT)
      ) u_wdog (
        .sys_clk(sys_clk),
        .rst(rst),
        .edge_seen(ch_if[g].edge_seen),
        .fail(wd_fail[g])
      );

      // these outputs come straight from front-end flip-flops
      assign mod_bit[g] = ch_if[g].dbit;
      assign mod_bit_stb[g] = ch_if[g].dstb;
      assign time_val[g] = ch_if[g].tval;
      assign time_stb[g] = ch_if[g].tstb;
      assign modulator_clock_pin_out[g] = ch_if[g].clk_out;
      assign modulator_clock_pin_oe[g] = ch_if[g].clk_oe;
    end
  endgenerate

  always_comb begin
    nx = st;
    // set wins over the read clear: a live source keeps its flag
    if (flag_rd) begin
      nx.flags[11:0] = src12;
    end else begin
      nx.flags[11:0] = st.flags[11:0] | src12;
    end
    // flag read leaves new-data bits alone
    nx.flags[15:12] = (st.flags[15:12] & ~data_rd) | ack_set;
    for (int c = 0; c < fic_pkg::NCH; c++) begin
      if (ctrl_wr[c]) begin
        nx.ctrl[c] = reg_wdata[4:0];
      end
      if (st.ctrl[c][1:0] == fic_pkg::FMT_MAN) begin
        nx.mstat[c] = man_per[c];
      end
    end
    nx.rdata = 16'h0000;
    if (flag_rd) begin
      nx.rdata = st.flags;
    end
    for (int c = 0; c < fic_pkg::NCH; c++) begin
      if (ctrl_rd[c]) begin
        nx.rdata = {st.mstat[c], st.ctrl[c]};
      end
    end
    nx.int_pin = any_irq ^ interrupt_polarity;
    nx.ack_pin = any_ack ^ new_data_pin_polarity;
    // one divider feeds every channel that drives its clock pin
    if (st.div_cnt >= 8'(CLK_DIV - 1)) begin
      nx.div_cnt = 8'h00;
      nx.div_tick = 1'b1;
    end else begin
      nx.div_cnt = st.div_cnt + 8'h01;
      nx.div_tick = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st.flags <= fic_pkg::FLAG_RST;
      st.ctrl <= {fic_pkg::NCH{fic_pkg::CTRL_RST}};
      st.mstat <= {fic_pkg::NCH{fic_pkg::STAT_RST}};
      st.rdata <= 16'h0000;
      st.int_pin <= 1'b0;
      st.ack_pin <= 1'b0;
      st.div_cnt <= 8'h00;
      st.div_tick <= 1'b0;
    end else begin
      st <= nx;
    end
  end

  assign reg_rdata = st.rdata;
  assign int_pin = st.int_pin;
  assign new_data_pin = st.ack_pin;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  generate
    for (g = 0; g < fic_pkg::NCH; g++) begin : g_chk
      a_hi_flag_set: assert property (hi_src[g] |=> st.flags[2*g])
        else $error("high flag not set");
      a_lo_flag_set: assert property (lo_src[g] |=> st.flags[2*g+1])
        else $error("low flag not set");
      a_mf_flag_set: assert property (mf_src[g] |=> st.flags[8+g])
        else $error("modulator fail flag not set");
      a_ack_flag_clear: assert property (
        (data_rd[g] && !ack_set[g]) |=> !st.flags[12+g])
        else $error("new-data flag survived data read");
      a_ack_flag_gate: assert property (
        (!new_data_flag_enable[g] && !st.flags[12+g]) |=> !st.flags[12+g])
        else $error("new-data flag set while disabled");
      a_ack_flag_hold: assert property (
        (st.flags[12+g] && !data_rd[g]) |=> st.flags[12+g])
        else $error("new-data flag lost without data read");
      a_ctrl_write: assert property (ctrl_wr[g] |=> st.ctrl[g] == $past(wlow))
        else $error("control bits not written");
      a_stat_hold: assert property (
        (st.ctrl[g][1:0] != fic_pkg::FMT_MAN) |=> $stable(st.mstat[g]))
        else $error("status moved outside decoder mode");
    end
  endgenerate

  a_flag_read: assert property (flag_rd |=> st.flags[11:0] == $past(src12))
    else $error("flag read clear wrong");
  a_flag_rdata: assert property (flag_rd |=> reg_rdata == $past(st.flags))
    else $error("flag read data wrong");
  a_int_level: assert property (
    1'b1 |=> int_pin == ($past(any_irq) ^ $past(interrupt_polarity)))
    else $error("interrupt pin level wrong");
  a_ack_level: assert property (
    1'b1 |=> new_data_pin == ($past(any_ack) ^ $past(new_data_pin_polarity)))
    else $error("new-data pin level wrong");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not idle");

  c_read_live: cover property (flag_rd && (|src12));
  c_data_clear: cover property ((|data_rd) ##1 !st.ack_pin);
  c_man_mode: cover property (ctrl_wr[0] && reg_wdata[1:0] == fic_pkg::FMT_MAN);
  c_int_rise: cover property (!any_irq ##1 any_irq);
endmodule

// >>> rtl/fic_wdog.sv
// modulator clock watchdog for one channel
// assumes edge_seen is a one-cycle pulse per modulator clock rise, or per data edge in Manchester format
`timescale 1ns/10ps
module fic_wdog #(
  parameter int unsigned LIMIT = fic_pkg::WD_LIMIT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic edge_seen,
  output logic fail
);
  typedef struct packed {
    logic [6:0] cnt;
    logic fail;
  } fic_wd_st_t;
  fic_wd_st_t st, nx;

  always_comb begin
    nx = st;
    if (edge_seen) begin
      nx.cnt = 7'h00;
      nx.fail = 1'b0;
    end else if (st.cnt == 7'(LIMIT - 1)) begin
      nx.fail = 1'b1;
    end else begin
      nx.cnt = st.cnt + 7'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign fail = st.fail;

  a_wd_trip: assert property (@(posedge sys_clk) disable iff (rst)
    (st.cnt == 7'(LIMIT - 1) && !edge_seen) |=> fail)
    else $error("watchdog did not trip");
  a_wd_clear: assert property (@(posedge sys_clk) disable iff (rst)
    edge_seen |=> !fail && st.cnt == 7'h00)
    else $error("watchdog not cleared by edge");
endmodule

// >>> tb/fic_host.sv
// host processor model: drives the register port of the flag and control block
// assumes single-cycle strobes and read data standing only in the cycle after the read
`timescale 1ns/10ps
module fic_host (
  input wire logic sys_clk,
  output logic [6:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // data is taken at the edge that closes its only valid cycle
  task automatic rd_reg(input logic [6:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
endmodule

// >>> tb/tb.sv
// self-checking bench for the flag register and channel control block
// assumes the host model above and a pin-level modulator drive made here
`timescale 1ns/10ps
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic [3:0][15:0] cmp_val = '0;
  logic [3:0][15:0] thr_high = {4{16'h0100}};
  logic [3:0][15:0] thr_low = {4{16'hff00}};
  logic [3:0] high_en = 4'h0;
  logic [3:0] low_en = 4'h0;
  logic [3:0] fail_en = 4'h0;
  logic master = 1'b0;
  logic [3:0] nd_en = 4'h0;
  logic [3:0] filt_upd = 4'h0;
  logic ipol = 1'b0;
  logic npol = 1'b0;
  logic [3:0] mclk_tb = 4'h0;
  logic [3:0] mclk_pin;
  logic [3:0] mclk_out;
  logic [3:0] mclk_oe;
  logic [3:0] mod_data = 4'b1011;
  logic sh_a = 1'b0;
  logic sh_b = 1'b0;
  logic [3:0] mod_bit;
  logic [3:0] mod_bit_stb;
  logic [3:0][15:0] time_val;
  logic [3:0] time_stb;
  logic int_pin;
  logic new_data_pin;
  logic mclk_run = 1'b0;
  logic man_run = 1'b0;
  int man_gap = 16;
  int man_cnt = 0;
  logic cnt_on = 1'b0;
  logic [3:0][7:0] nb = '0;
  logic [15:0] last_t = 16'h0000;
  logic [7:0] nt = 8'h00;
  int cyc = 0;
  int n_mismatch = 0;
  int total_checks = 0;

  always #50 sys_clk = ~sys_clk;
  // clock pin level: the design wins while it drives
  assign mclk_pin = (mclk_oe & mclk_out) | (~mclk_oe & mclk_tb);

  fic_host fic_host_i (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  fic_top #(.CLK_DIV(4), .MAN_MIN(6), .WD_LIMIT(64)) fic_top_i (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmp_val(cmp_val), .thr_high(thr_high), .thr_low(thr_low),
    .high_irq_en(high_en), .low_irq_en(low_en), .mod_fail_irq_en(fail_en),
    .irq_master_en(master), .new_data_flag_enable(nd_en), .filt_upd(filt_upd),
    .interrupt_polarity(ipol), .new_data_pin_polarity(npol),
    .modulator_clock_pin_in(mclk_pin), .modulator_clock_pin_out(mclk_out),
    .modulator_clock_pin_oe(mclk_oe), .mod_data(mod_data), .sample_hold_a(sh_a),
    .sample_hold_b(sh_b), .mod_bit(mod_bit), .mod_bit_stb(mod_bit_stb),
    .time_val(time_val), .time_stb(time_stb), .int_pin(int_pin),
    .new_data_pin(new_data_pin));

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (mclk_run && cyc[0]) begin
      mclk_tb <= ~mclk_tb;
    end
    man_cnt <= (man_cnt >= man_gap - 1) ? 0 : man_cnt + 1;
    // every edge is mid-bit, as in a manchester stream of alternating bits
    if (man_run && man_cnt >= man_gap - 1) begin
      mod_data[2] <= ~mod_data[2];
    end
    for (int i = 0; i < 4; i++) begin
      nb[i] <= cnt_on ? nb[i] + 8'(mod_bit_stb[i]) : 8'h00;
    end
    if (time_stb[0]) begin
      last_t <= time_val[0];
      nt <= nt + 8'h01;
    end
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] d;
    fic_host_i.rd_reg(a, d);
    chk(d, exp);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic shr(input logic b, input int gap);
    wt(gap);
    if (b) sh_b <= 1'b1;
    else sh_a <= 1'b1;
    @(posedge sys_clk);
    sh_a <= 1'b0;
    sh_b <= 1'b0;
  endtask

  task automatic upd();
    @(posedge sys_clk);
    filt_upd <= 4'h1;
    @(posedge sys_clk);
    filt_upd <= 4'h0;
  endtask

  task automatic t_reset();
    rdchk(fic_pkg::FLAG_ADDR, 16'h0000);
    fic_host_i.wr_reg(fic_pkg::FLAG_ADDR, 16'hffff);
    rdchk(fic_pkg::FLAG_ADDR, 16'h0000);
    fic_host_i.wr_reg(7'h30, 16'hffff);
    rdchk(7'h30, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rdchk(fic_pkg::CTRL_ADDR[i], 16'h0000);
      fic_host_i.wr_reg(fic_pkg::CTRL_ADDR[i], 16'hffff);
      rdchk(fic_pkg::CTRL_ADDR[i], 16'h001f);
      fic_host_i.wr_reg(fic_pkg::CTRL_ADDR[i], 16'h0000);
    end
  endtask

  task automatic t_thresh();
    master <= 1'b1;
    high_en <= 4'h7;
    low_en <= 4'hf;
    // equal values hit both compares; channel 4 high is masked
    cmp_val <= {16'h7fff, 16'h7fff, 16'hff00, 16'h0100};
    wt(3);
    rdchk(fic_pkg::FLAG_ADDR, 16'h0019);
    rdchk(fic_pkg::FLAG_ADDR, 16'h0019);
    chk({15'h0, int_pin}, 16'h0001);
    cmp_val <= '0;
    wt(2);
    rdchk(fic_pkg::FLAG_ADDR, 16'h0019);
    rdchk(fic_pkg::FLAG_ADDR, 16'h0000);
    wt(2);
    chk({15'h0, int_pin}, 16'h0000);
  endtask

  task automatic t_fail();
    fail_en <= 4'h8;
    wt(80);
    rdchk(fic_pkg::FLAG_ADDR, 16'h0800);
    fail_en <= 4'hf;
    wt(3);
    rdchk(fic_pkg::FLAG_ADDR, 16'h0f00);
    rdchk(fic_pkg::FLAG_ADDR, 16'h0f00);
    mclk_run <= 1'b1;
    wt(6);
    rdchk(fic_pkg::FLAG_ADDR, 16'h0f00);
    rdchk(fic_pkg::FLAG_ADDR, 16'h0000);
    fail_en <= 4'h0;
  endtask

  task automatic t_newdata();
    nd_en <= 4'hd;
    filt_upd <= 4'hf;
    @(posedge sys_clk);
    filt_upd <= 4'h0;
    wt(2);
    rdchk(fic_pkg::FLAG_ADDR, 16'hd000);
    chk({15'h0, new_data_pin}, 16'h0001);
    rdchk(fic_pkg::FLAG_ADDR, 16'hd000);
    rdchk(fic_pkg::DATA_ADDR[0], 16'h0000);
    rdchk(fic_pkg::FLAG_ADDR, 16'hc000);
    rdchk(fic_pkg::DATA_ADDR[2], 16'h0000);
    chk({15'h0, new_data_pin}, 16'h0001);
    rdchk(fic_pkg::DATA_ADDR[3], 16'h0000);
    rdchk(fic_pkg::FLAG_ADDR, 16'h0000);
    chk({15'h0, new_data_pin}, 16'h0000);
    npol <= 1'b1;
    ipol <= 1'b1;
    nd_en <= 4'h0;
    wt(3);
    chk({14'h0, int_pin, new_data_pin}, 16'h0003);
    npol <= 1'b0;
    ipol <= 1'b0;
  endtask

  task automatic t_front();
    logic [15:0] d;
    logic [15:0] e;
    logic [3:0] o;
    man_run <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      fic_host_i.wr_reg(fic_pkg::CTRL_ADDR[i], 16'h0010 | 16'(i));
    end
    wt(2);
    chk({12'h0, mclk_oe}, 16'h000f);
    // driven clock toggles once per divider period of four cycles
    o = mclk_out;
    wt(4);
    chk({12'h0, mclk_out}, {12'h0, ~o});
    wt(40);
    cnt_on <= 1'b1;
    wt(64);
    cnt_on <= 1'b0;
    // one more edge so that exactly 64 strobe samples are counted
    @(posedge sys_clk);
    chk({8'h0, nb[0]}, 16'h0008);
    chk({8'h0, nb[1]}, 16'h0010);
    chk({8'h0, nb[2]}, 16'h0004);
    chk({8'h0, nb[3]}, 16'h0004);
    chk({15'h0, mod_bit[0]}, 16'h0001);
    fic_host_i.rd_reg(fic_pkg::CTRL_ADDR[2], d);
    chk({15'h0, d[15:5] >= 11'h00f && d[15:5] <= 11'h011}, 16'h0001);
    // a slower stream must show up in the status field
    man_gap <= 24;
    wt(60);
    fic_host_i.rd_reg(fic_pkg::CTRL_ADDR[2], d);
    chk(d, {11'h017, 5'h12});
    // leaving manchester must freeze the status field
    fic_host_i.wr_reg(fic_pkg::CTRL_ADDR[2], 16'h0010);
    man_gap <= 16;
    wt(60);
    fic_host_i.rd_reg(fic_pkg::CTRL_ADDR[2], e);
    chk(e, {11'h017, 5'h10});
    for (int i = 0; i < 4; i++) begin
      fic_host_i.wr_reg(fic_pkg::CTRL_ADDR[i], 16'h0000);
    end
    wt(2);
    chk({12'h0, mclk_oe}, 16'h0000);
    man_run <= 1'b0;
  endtask

  task automatic t_time();
    logic [15:0] t1;
    logic [7:0] n0;
    fic_host_i.wr_reg(fic_pkg::CTRL_ADDR[0], 16'h0004);
    shr(1'b0, 5);
    shr(1'b0, 20);
    wt(3);
    t1 = last_t;
    shr(1'b0, 30);
    wt(3);
    chk(last_t - t1, 16'h000d);
    fic_host_i.wr_reg(fic_pkg::CTRL_ADDR[0], 16'h000c);
    wt(3);
    n0 = nt;
    shr(1'b0, 5);
    shr(1'b0, 5);
    wt(3);
    chk({8'h0, nt}, {8'h0, n0});
    shr(1'b1, 5);
    wt(3);
    chk({8'h0, nt}, {8'h0, n0 + 8'h01});
    fic_host_i.wr_reg(fic_pkg::CTRL_ADDR[0], 16'h0008);
    upd();
    shr(1'b1, 25);
    wt(3);
    t1 = last_t;
    upd();
    shr(1'b1, 40);
    wt(3);
    chk(last_t - t1, 16'h000f);
  endtask

  initial begin
    wt(6);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_thresh();
    t_fail();
    t_newdata();
    t_front();
    t_time();
    give_verdict();
  end
endmodule
